// [core/bpm_pkg.sv]
// Constants for the burst and protection mode controller
// What this block does
// (RQ1) Blanking counter held at zero normally; counts once feedback drops below low-load level.
// (RQ2) Burst mode entered only when blanking reaches 20ms with feedback still low.
// (RQ3) Burst entry sets burst flag and turns internal bias off, stopping switching.
// (RQ4) In burst, feedback above wake level turns bias and switching back on.
// (RQ5) In burst, the reduced current-limit comparator replaces the normal limit.
// (RQ6) In burst, feedback down at sleep level turns bias off again.
// (RQ7) Feedback above high level ends burst and restores the full current limit.
// (RQ8) Latched shutdown persists until supply falls below the reset level.
// (RQ9) Overvoltage, heat, shorted winding, low pin latch; overload, undervoltage restart.
// (RQ10) Supply overvoltage counts only while feedback is also above high level.
// (RQ11) While latched, lockout runs start-up cell: on below 10.5V, off above 18V.
// (RQ12) While latched, no start-up phase and no switching ever begin.
// (RQ13) Over-temperature indication enters latched shutdown.
// (RQ14) Over-temperature and overvoltage pass an 8.0us spike filter first.
// (RQ15) In normal operation the main current limit ends each switching pulse.
// (RQ16) Secondary-fault comparator trip enters latched shutdown at once.
// (RQ17) Low restart-delay pin forces latch, ignored for 1ms after start-up.
// (RQ18) High feedback starts blanking; at 20ms the pin clamp is released.
// (RQ19) After blanking, pin reaching 4.0V enters restart after an 8.0us filter.
// (RQ20) After clamp release the pin charges up, extending blanking by capacitor.
// (RQ21) Supply undervoltage enters automatic restart and a new start-up cycle.
// (RQ22) Restart always runs a start-up with switching, then rechecks the fault.
// (RQ23) Blanking timer disabled during soft start.
// (RQ24) Burst uses basic blanking only; restart uses basic plus extended blanking.
// (RQ25) Comparator outputs synchronised before use; timers count clock cycles.
// (RQ26) Latched shutdown outranks restart and burst, forcing switching off.
package bpm_pkg;
  // Clock rate
  localparam int CLK_MHZ = 250;
  localparam int CLK_KHZ = 250000;
  // Times as printed
  localparam int BLANK_MS = 20;
  localparam int SPIKE_NS = 8000;
  localparam int EXT_LATCH_MS = 1;
  // Cycle counts, least times rounded up
  localparam int BLANK_CYC = BLANK_MS * CLK_KHZ;
  localparam int SPIKE_CYC = (SPIKE_NS * CLK_MHZ + 999) / 1000;
  localparam int EXT_LATCH_CYC = EXT_LATCH_MS * CLK_KHZ;
  localparam logic [11:0] SPIKE_CNT = 12'(SPIKE_CYC);
  // Comparator input positions
  localparam int NIN = 16;
  localparam int I_FEED_LOW = 0;
  localparam int I_FEED_WAKE = 1;
  localparam int I_FEED_SLEEP = 2;
  localparam int I_FEED_HIGH = 3;
  localparam int I_VCC_OV = 4;
  localparam int I_VCC_UV = 5;
  localparam int I_VCC_RST = 6;
  localparam int I_VCC_ON = 7;
  localparam int I_VCC_LO = 8;
  localparam int I_OTP = 9;
  localparam int I_CS_MAIN = 10;
  localparam int I_CS_RED = 11;
  localparam int I_CS_FAULT = 12;
  localparam int I_PIN_LOW = 13;
  localparam int I_PIN_HIGH = 14;
  localparam int I_SOFT = 15;
  // Spike filter channels
  localparam int F_OVP = 0;
  localparam int F_OTP = 1;
  localparam int F_PIN = 2;
  // Register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_EXT_EN = 0;
  localparam int ST_BIAS = 6;
  localparam int ST_CLAMP = 7;
  localparam int ST_CELL = 8;
  localparam int ST_CAUSE = 9;
  // Operating modes
  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_START   = 6'h02,
    ST_NORMAL  = 6'h04,
    ST_BURST   = 6'h08,
    ST_RESTART = 6'h10,
    ST_LATCH   = 6'h20
  } bpm_state_t;
endpackage : bpm_pkg

// [core/bpm_ctrl.sv]
// Burst, latched-off and auto-restart mode control with Wishbone registers
`timescale 1ns/1ps
module bpm_ctrl #(
  parameter int BLANK_CYCLES = bpm_pkg::BLANK_CYC,
  parameter int EXT_LATCH_CYCLES = bpm_pkg::EXT_LATCH_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Feedback comparators
  input wire logic feedback_low_i,
  input wire logic feedback_wake_i,
  input wire logic feedback_sleep_i,
  input wire logic feedback_high_i,
  // Supply comparators
  input wire logic vcc_ov_i,
  input wire logic vcc_uv_i,
  input wire logic vcc_rst_i,
  input wire logic vcc_on_i,
  input wire logic vcc_lo_i,
  // Current sense and temperature
  input wire logic otp_i,
  input wire logic cs_main_i,
  input wire logic cs_red_i,
  input wire logic cs_fault_i,
  // Restart delay pin and soft start
  input wire logic pin_low_i,
  input wire logic pin_high_i,
  input wire logic soft_start_i,
  // Control outputs
  output logic bias_en_o,
  output logic reduced_limit_o,
  output logic switch_en_o,
  output logic pulse_end_o,
  output logic startup_cell_o,
  output logic pin_clamp_o,
  output logic burst_o,
  output logic latched_o
);
  import bpm_pkg::*;

  logic [NIN-1:0] raw;
  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] s;
  bpm_state_t st_q;
  bpm_state_t st_d;
  logic [22:0] blank_q;
  logic blank_done;
  logic [17:0] ext_q;
  logic ext_done;
  logic [2:0] filt_in;
  logic [2:0] filt_q;
  logic [11:0] filt_cnt_q [3];
  logic clamp_q;
  logic bias_q;
  logic bias_d;
  logic cell_q;
  logic [3:0] cause_q;
  logic [3:0] cause;
  logic latch_go;
  logic burst_go;
  logic active;
  logic [31:0] ctrl_q;
  logic req;

  // Gather comparator outputs
  assign raw = {soft_start_i, pin_high_i, pin_low_i, cs_fault_i, cs_red_i, cs_main_i,
                otp_i, vcc_lo_i, vcc_on_i, vcc_rst_i, vcc_uv_i, vcc_ov_i,
                feedback_high_i, feedback_sleep_i, feedback_wake_i, feedback_low_i};

  // Two-stage synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= '0;
      s <= '0;
    end else begin
      sync1_q <= raw; // [RQ25]
      s <= sync1_q;
    end
  end

  // States in which the converter is running
  assign active = (st_q == ST_START) || (st_q == ST_NORMAL) || (st_q == ST_BURST);

  // Blanking counter, only outside soft start
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blank_q <= '0;
    end else if (st_q == ST_NORMAL && (s[I_FEED_LOW] || s[I_FEED_HIGH])) begin // [RQ1] [RQ23]
      if (!blank_done) begin
        blank_q <= blank_q + 23'h1; // [RQ25]
      end
    end else begin
      blank_q <= '0; // [RQ1]
    end
  end
  assign blank_done = (blank_q == 23'(BLANK_CYCLES));

  // Pin clamp released after basic blanking under overload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clamp_q <= 1'b1;
    end else if (st_q == ST_NORMAL && s[I_FEED_HIGH] && blank_done) begin
      clamp_q <= 1'b0; // [RQ18] [RQ20]
    end else if (!(st_q == ST_NORMAL && s[I_FEED_HIGH])) begin
      clamp_q <= 1'b1;
    end
  end

  // Start-up blanking of the external latch request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q <= '0;
    end else if (st_q != ST_START && st_d == ST_START) begin
      ext_q <= '0; // [RQ17]
    end else if (!ext_done) begin
      ext_q <= ext_q + 18'h1;
    end
  end
  assign ext_done = (ext_q == 18'(EXT_LATCH_CYCLES));

  // Inputs to the spike filters
  always_comb begin
    filt_in = '0;
    filt_in[F_OVP] = s[I_VCC_OV] && s[I_FEED_HIGH]; // [RQ10]
    filt_in[F_OTP] = s[I_OTP]; // [RQ13]
    filt_in[F_PIN] = !clamp_q && s[I_PIN_HIGH] && s[I_FEED_HIGH]; // [RQ19] [RQ24]
  end

  // Spike filters: output rises after a full quiet-free window
  for (genvar i = 0; i < 3; i++) begin : g_filt
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        filt_cnt_q[i] <= '0;
        filt_q[i] <= 1'b0;
      end else if (!filt_in[i]) begin
        filt_cnt_q[i] <= '0;
        filt_q[i] <= 1'b0;
      end else if (filt_cnt_q[i] != SPIKE_CNT) begin
        filt_cnt_q[i] <= filt_cnt_q[i] + 12'h1; // [RQ14]
      end else begin
        filt_q[i] <= 1'b1; // [RQ14] [RQ19]
      end
    end
  end

  // Latch causes: overvoltage, heat, secondary fault, low pin
  always_comb begin
    cause = '0;
    cause[0] = filt_q[F_OVP]; // [RQ9]
    cause[1] = filt_q[F_OTP]; // [RQ13]
    cause[2] = s[I_CS_FAULT]; // [RQ16]
    cause[3] = s[I_PIN_LOW] && ext_done && ctrl_q[CTRL_EXT_EN]; // [RQ17]
  end
  assign latch_go = active && (cause != 4'h0);
  assign burst_go = blank_done && s[I_FEED_LOW];

  // Mode sequencing, latch first
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF, ST_RESTART: begin
        if (s[I_VCC_ON]) begin
          st_d = ST_START; // [RQ22]
        end
      end
      ST_START: begin
        if (latch_go) begin
          st_d = ST_LATCH; // [RQ26]
        end else if (s[I_VCC_UV]) begin
          st_d = ST_RESTART; // [RQ21]
        end else if (!s[I_SOFT]) begin
          st_d = ST_NORMAL; // [RQ22]
        end
      end
      ST_NORMAL: begin
        if (latch_go) begin
          st_d = ST_LATCH; // [RQ9] [RQ26]
        end else if (s[I_VCC_UV] || filt_q[F_PIN]) begin
          st_d = ST_RESTART; // [RQ9] [RQ19] [RQ21]
        end else if (burst_go) begin
          st_d = ST_BURST; // [RQ2]
        end
      end
      ST_BURST: begin
        if (latch_go) begin
          st_d = ST_LATCH; // [RQ26]
        end else if (s[I_VCC_UV]) begin
          st_d = ST_RESTART; // [RQ21]
        end else if (s[I_FEED_HIGH]) begin
          st_d = ST_NORMAL; // [RQ7]
        end
      end
      ST_LATCH: begin
        if (s[I_VCC_RST]) begin
          st_d = ST_OFF; // [RQ8]
        end
      end
      default: st_d = ST_OFF;
    endcase
  end

  // Mode register and latch cause capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_OFF;
      cause_q <= '0;
    end else begin
      st_q <= st_d;
      if (st_q != ST_LATCH && st_d == ST_LATCH) begin
        cause_q <= cause;
      end else if (st_d != ST_LATCH) begin
        cause_q <= '0;
      end
    end
  end

  // Internal bias: off on burst entry, bursts between wake and sleep
  always_comb begin
    bias_d = 1'b0;
    if (st_d == ST_START || st_d == ST_NORMAL) begin
      bias_d = 1'b1;
    end else if (st_d == ST_BURST) begin
      if (st_q != ST_BURST) begin
        bias_d = 1'b0; // [RQ3]
      end else if (s[I_FEED_WAKE]) begin
        bias_d = 1'b1; // [RQ4]
      end else if (s[I_FEED_SLEEP]) begin
        bias_d = 1'b0; // [RQ6]
      end else begin
        bias_d = bias_q;
      end
    end
  end

  // Undervoltage lockout hysteresis for the start-up cell
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cell_q <= 1'b1;
    end else if (active) begin
      cell_q <= 1'b0;
    end else if (s[I_VCC_LO]) begin
      cell_q <= 1'b1; // [RQ11]
    end else if (s[I_VCC_ON]) begin
      cell_q <= 1'b0; // [RQ11]
    end
  end

  // Registered control outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bias_q <= 1'b0;
      bias_en_o <= 1'b0;
      reduced_limit_o <= 1'b0;
      switch_en_o <= 1'b0;
      burst_o <= 1'b0;
      latched_o <= 1'b0;
      pin_clamp_o <= 1'b1;
      startup_cell_o <= 1'b1;
      pulse_end_o <= 1'b0;
    end else begin
      bias_q <= bias_d;
      bias_en_o <= bias_d; // [RQ3] [RQ26]
      reduced_limit_o <= (st_d == ST_BURST); // [RQ5] [RQ7]
      switch_en_o <= bias_d && (st_d != ST_LATCH); // [RQ12] [RQ26]
      burst_o <= (st_d == ST_BURST); // [RQ3]
      latched_o <= (st_d == ST_LATCH);
      pin_clamp_o <= clamp_q; // [RQ20]
      startup_cell_o <= cell_q;
      // Same mode as the limit select, so both change on one edge
      if (st_d == ST_BURST) begin
        pulse_end_o <= s[I_CS_RED]; // [RQ5]
      end else begin
        pulse_end_o <= s[I_CS_MAIN]; // [RQ15]
      end
    end
  end

  // Wishbone classic slave, one wait state
  assign req = cyc_i && stb_i && !ack_o;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= '0;
      ctrl_q <= CTRL_RST;
    end else begin
      ack_o <= req;
      dat_o <= '0;
      // Write lands on the edge at which the master sees ack
      if (ack_o && cyc_i && stb_i && we_i && adr_i == ADDR_CTRL) begin
        for (int b = 0; b < 4; b++) begin
          if (sel_i[b]) begin
            ctrl_q[8*b +: 8] <= dat_i[8*b +: 8];
          end
        end
      end
      if (req && !we_i && adr_i == ADDR_CTRL) begin
        dat_o <= ctrl_q;
      end else if (req && !we_i && adr_i == ADDR_STAT) begin
        dat_o <= {19'h0, cause_q, cell_q, !clamp_q, bias_q, st_q};
      end
    end
  end

  // Checks
  blank_zero_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    (st_q != ST_NORMAL) |=> (blank_q == 23'h0))
    else $error("blanking counter not held at zero");
  burst_entry_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    (st_q != ST_BURST) ##1 (st_q == ST_BURST) |-> $past(burst_go))
    else $error("burst entered without blanking");
  burst_bias_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ3]
    (st_q == ST_NORMAL) ##1 (st_q == ST_BURST) |-> !bias_en_o && burst_o)
    else $error("bias on at burst entry");
  wake_bias_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    (st_q == ST_BURST && st_d == ST_BURST && s[I_FEED_WAKE]) |=> bias_en_o && switch_en_o)
    else $error("burst did not wake");
  sleep_bias_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    (st_q == ST_BURST && st_d == ST_BURST && !s[I_FEED_WAKE] && s[I_FEED_SLEEP])
    |=> !bias_en_o)
    else $error("burst did not sleep");
  reduced_sel_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    reduced_limit_o == (st_q == ST_BURST))
    else $error("current limit selection wrong");
  burst_exit_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    (st_q == ST_BURST && s[I_FEED_HIGH] && !latch_go && !s[I_VCC_UV])
    |=> ##1 !reduced_limit_o)
    else $error("full limit not restored");
  latch_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    (st_q == ST_LATCH && !s[I_VCC_RST]) |=> (st_q == ST_LATCH))
    else $error("latch left early");
  latch_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ12]
    (st_q == ST_LATCH) |-> !switch_en_o && !bias_en_o)
    else $error("switching while latched");
  fault_latch_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ16]
    (active && s[I_CS_FAULT]) |=> (st_q == ST_LATCH) ##1 latched_o)
    else $error("secondary fault not latched");
  uv_restart_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ21]
    (active && s[I_VCC_UV]) |=> (st_q == ST_RESTART || st_q == ST_LATCH))
    else $error("undervoltage did not restart");
  ovp_filter_a: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ14]
    $rose(filt_q[F_OVP]) |-> $past(filt_in[F_OVP]) && $past(filt_in[F_OVP], 8)
    && ($past(filt_cnt_q[F_OVP]) == SPIKE_CNT))
    else $error("overvoltage filter too short");
  burst_cycle_c: cover property (@(posedge clk_i) disable iff (rst_i)
    burst_o && !bias_en_o ##1 bias_en_o [*2] ##1 !bias_en_o);
  latch_reset_c: cover property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_LATCH) ##1 (st_q == ST_OFF));
  restart_c: cover property (@(posedge clk_i) disable iff (rst_i)
    (st_q == ST_RESTART) ##1 (st_q == ST_START));
endmodule : bpm_ctrl

// [dv/bpm_ctrl_tb_top.sv]
// Self-checking bench for the burst and protection mode controller
`timescale 1ns/1ps
module bpm_ctrl_tb_top;
  import bpm_pkg::*;
  localparam int BLK = 50;
  localparam int EXL = 20;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic ack_o, bias_en_o, reduced_limit_o, switch_en_o, pulse_end_o;
  logic startup_cell_o, pin_clamp_o, burst_o, latched_o;
  logic [NIN-1:0] cmp = '0;
  logic [7:0] outs;
  int n_fail = 0;
  int total_checks = 0;
  int cyc;
  int exp_q[$];
  int cause_in[4] = '{I_VCC_OV, I_OTP, I_CS_FAULT, I_PIN_LOW};
  int lim[4] = '{900, 900, 3, 10};

  // Outputs gathered: bias, reduced, switch, pulse end, cell, clamp, burst, latch
  assign outs = {bias_en_o, reduced_limit_o, switch_en_o, pulse_end_o,
                 startup_cell_o, pin_clamp_o, burst_o, latched_o};

  // Device under test with shortened blanking and latch-ignore counts
  bpm_ctrl #(.BLANK_CYCLES(BLK), .EXT_LATCH_CYCLES(EXL)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .feedback_low_i(cmp[I_FEED_LOW]), .feedback_wake_i(cmp[I_FEED_WAKE]),
    .feedback_sleep_i(cmp[I_FEED_SLEEP]), .feedback_high_i(cmp[I_FEED_HIGH]),
    .vcc_ov_i(cmp[I_VCC_OV]), .vcc_uv_i(cmp[I_VCC_UV]), .vcc_rst_i(cmp[I_VCC_RST]),
    .vcc_on_i(cmp[I_VCC_ON]), .vcc_lo_i(cmp[I_VCC_LO]), .otp_i(cmp[I_OTP]),
    .cs_main_i(cmp[I_CS_MAIN]), .cs_red_i(cmp[I_CS_RED]),
    .cs_fault_i(cmp[I_CS_FAULT]), .pin_low_i(cmp[I_PIN_LOW]),
    .pin_high_i(cmp[I_PIN_HIGH]), .soft_start_i(cmp[I_SOFT]),
    .bias_en_o(bias_en_o), .reduced_limit_o(reduced_limit_o),
    .switch_en_o(switch_en_o), .pulse_end_o(pulse_end_o),
    .startup_cell_o(startup_cell_o), .pin_clamp_o(pin_clamp_o),
    .burst_o(burst_o), .latched_o(latched_o)
  );

  // Clock, 4 ns period
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // Compare one value and count it
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Closing report and end of run
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // A wait that ran out counts as a mismatch
  task automatic timeout(input string what);
    n_fail++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    give_verdict();
  endtask : timeout

  task automatic ticks(input int n);
    repeat (n) @(posedge clk_i);
  endtask : ticks

  // Classic single Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 50);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
    if (k >= 50) timeout("bus ack");
  endtask : wb

  // Poll the status mode field until it shows the wanted mode
  task automatic wait_mode(input logic [5:0] m, input int n);
    int k;
    k = 0;
    do begin
      wb(1'b0, ADDR_STAT, 32'h0, q);
      k++;
    end while (q[5:0] !== m && k < n);
    if (q[5:0] !== m) timeout("mode wait");
  endtask : wait_mode

  // Supply up, soft start, then normal running
  task automatic start_up();
    cmp[I_VCC_RST] <= 1'b0;
    cmp[I_VCC_ON] <= 1'b1;
    cmp[I_SOFT] <= 1'b1;
    wait_mode(ST_START, 20);
    cmp[I_VCC_ON] <= 1'b0;
    cmp[I_SOFT] <= 1'b0;
    wait_mode(ST_NORMAL, 20);
  endtask : start_up

  // Run-length guard
  initial begin
    ticks(100000);
    timeout("run length");
  end

  // Main sequence
  initial begin
    void'($urandom(73));
    ticks(16);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check("reset outputs", outs, 8'h0c);
    wb(1'b0, ADDR_CTRL, 32'h0, q);
    check("ctrl reset", q, CTRL_RST);
    wb(1'b1, 4'h8, $urandom, q);
    wb(1'b0, 4'h8, 32'h0, q);
    check("unmapped read", q, 32'h0);
    wb(1'b0, ADDR_STAT, 32'h0, q);
    check("status reset", q, 32'h0000_0101);
    // Normal running, then burst entry after a broken low-load window
    start_up();
    check("switch after start", {switch_en_o, startup_cell_o}, 2'b10);
    cmp[I_FEED_LOW] <= 1'b1;
    ticks(BLK / 2);
    cmp[I_FEED_LOW] <= 1'b0;
    ticks(6);
    check("no early burst", burst_o, 1'b0);
    cmp[I_FEED_LOW] <= 1'b1;
    cyc = 0;
    while (burst_o !== 1'b1 && cyc < BLK + 40) begin
      @(posedge clk_i);
      cyc++;
    end
    if (cyc >= BLK + 40) timeout("burst entry");
    check("burst delay", 32'(cyc >= BLK), 32'h1);
    check("burst entry", outs & 8'he3, 8'h42);
    cmp[I_FEED_LOW] <= 1'b0;
    cmp[I_CS_RED] <= 1'b1;
    cmp[I_FEED_WAKE] <= 1'b1;
    ticks(5);
    check("burst wake", {bias_en_o, pulse_end_o}, 2'b11);
    cmp[I_CS_RED] <= 1'b0;
    cmp[I_FEED_WAKE] <= 1'b0;
    cmp[I_FEED_SLEEP] <= 1'b1;
    ticks(5);
    check("burst sleep", bias_en_o, 1'b0);
    cmp[I_FEED_SLEEP] <= 1'b0;
    cmp[I_FEED_HIGH] <= 1'b1;
    ticks(5);
    check("burst exit", {burst_o, reduced_limit_o}, 2'b00);
    cmp[I_CS_MAIN] <= 1'b1;
    ticks(5);
    check("main limit", pulse_end_o, 1'b1);
    cmp[I_CS_MAIN] <= 1'b0;
    // Overload: clamp release after blanking, restart after the pin filter
    cyc = 0;
    while (pin_clamp_o !== 1'b0 && cyc < BLK + 40) begin
      @(posedge clk_i);
      cyc++;
    end
    if (cyc >= BLK + 40) timeout("clamp release");
    check("clamp release", 32'(cyc >= BLK - 10 && cyc < BLK + 40), 32'h1);
    cmp[I_PIN_HIGH] <= 1'b1;
    ticks(1000);
    check("pin filter", switch_en_o, 1'b1);
    wait_mode(ST_RESTART, 800);
    check("restart", {switch_en_o, latched_o}, 2'b00);
    cmp[I_FEED_HIGH] <= 1'b0;
    cmp[I_PIN_HIGH] <= 1'b0;
    start_up();
    cmp[I_VCC_UV] <= 1'b1;
    wait_mode(ST_RESTART, 10);
    check("undervoltage", switch_en_o, 1'b0);
    cmp[I_VCC_UV] <= 1'b0;
    start_up();
    check("resume", switch_en_o, 1'b1);
    // Every latch cause, release only through supply collapse
    for (int c = 0; c < 4; c++) begin
      ticks($urandom_range(1, 30));
      exp_q.push_back(1 << c);
      if (c == 0) begin
        cmp[I_VCC_OV] <= 1'b1;
        ticks(2100);
        check("overvoltage alone", latched_o, 1'b0);
        cmp[I_FEED_HIGH] <= 1'b1;
      end
      if (c == 3) begin
        wb(1'b1, ADDR_CTRL, 32'h0, q);
        cmp[I_PIN_LOW] <= 1'b1;
        ticks(100);
        check("pin disabled", latched_o, 1'b0);
        wb(1'b1, ADDR_CTRL, $urandom | 32'h1, q);
      end
      cmp[cause_in[c]] <= 1'b1;
      if (c == 1) begin
        ticks(1000);
        check("spike filter", latched_o, 1'b0);
      end
      wait_mode(ST_LATCH, lim[c]);
      check("latch cause", q[12:9], exp_q.pop_front());
      check("latch outputs", {latched_o, switch_en_o, burst_o}, 3'b100);
      cmp[cause_in[c]] <= 1'b0;
      cmp[I_FEED_HIGH] <= 1'b0;
      cmp[I_VCC_LO] <= 1'b1;
      ticks(5);
      check("cell on", startup_cell_o, 1'b1);
      cmp[I_VCC_LO] <= 1'b0;
      cmp[I_VCC_ON] <= 1'b1;
      cmp[I_SOFT] <= 1'b1;
      ticks(5);
      check("cell off", {startup_cell_o, switch_en_o}, 2'b00);
      wait_mode(ST_LATCH, 2);
      cmp[I_VCC_ON] <= 1'b0;
      cmp[I_VCC_RST] <= 1'b1;
      wait_mode(ST_OFF, 10);
      check("latch cleared", latched_o, 1'b0);
      start_up();
    end
    // Pin pulled low through start-up: ignored for the first stretch
    wb(1'b1, ADDR_STAT, 32'hffff_ffff, q);
    cmp[I_VCC_UV] <= 1'b1;
    wait_mode(ST_RESTART, 10);
    cmp[I_VCC_UV] <= 1'b0;
    cmp[I_PIN_LOW] <= 1'b1;
    cmp[I_VCC_ON] <= 1'b1;
    cmp[I_SOFT] <= 1'b1;
    wait_mode(ST_START, 20);
    ticks(EXL / 2);
    check("pin ignored", latched_o, 1'b0);
    wait_mode(ST_LATCH, 20);
    check("pin latch", q[12:9], 4'h8);
    give_verdict();
  end
endmodule : bpm_ctrl_tb_top
